// ### logic/anat_pkg.sv
// constants, carrier types and reset values of the nor access block
// ****************************************************************
// Overview of operation
// - single access chip select length scaled
// - burst lengthens chip select by page intervals
// - latch strobe release placed relative to select
// - latch strobe assert placed relative to select
// - read strobe assert placed relative to select
// - single read strobe release relative to select
// - burst read strobe release extended by pages
// - write strobe assert placed relative to select
// - write strobe release placed relative to select
// - address, enables, data valid before select
// - address invalid gap between accesses
// - byte enables valid one cycle length
// - burst byte enables add page intervals
// - single read samples after sample delay
// - first page word uses same sample delay
// - later page words every page interval
// - multiplier zero means x1 for all
// - divider zero: bus clock equals functional
// - functional clock never driven on pins
// - four chip selects, two wait inputs
// ****************************************************************
package anat_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int FIELD_W = 5;   // on/off/cycle/sample fields
    localparam int PAGE_W  = 4;   // page interval and gap fields
    localparam int BURST_W = 2;   // burst length minus one
    localparam int EXT_W   = 7;   // burst extension width
    localparam int T_W     = 10;  // timeline in half functional periods
    localparam int ADDR_W  = 27;  // word address pins
    localparam int DATA_W  = 16;  // data pins
    localparam int NUM_CS  = 4;   // chip selects
    localparam int NUM_WT  = 2;   // wait inputs
    localparam int DIV_W   = 2;   // bus clock divider field
    localparam int NUM_EDGE = 12; // placed timeline points

    // ****************************************************************
    // timeline point indices
    // ****************************************************************
    localparam int E_CS_ON   = 0;
    localparam int E_CS_OFF  = 1;
    localparam int E_LAT_ON  = 2;
    localparam int E_LAT_OFF = 3;
    localparam int E_RD_ON   = 4;
    localparam int E_RD_OFF  = 5;
    localparam int E_WR_ON   = 6;
    localparam int E_WR_OFF  = 7;
    localparam int E_CYC_END = 8;
    localparam int E_SAMPLE  = 9;
    localparam int E_PAGE    = 10;
    localparam int E_GAP     = 11;

    // ****************************************************************
    // small constants
    // ****************************************************************
    localparam logic [T_W-1:0]     T_ONE   = 10'h001;
    localparam logic [T_W-1:0]     T_ZERO  = 10'h000;
    localparam logic [DIV_W-1:0]   DIV_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [ADDR_W-1:0]  ADDR_ONE = 27'h0000001;

    // ****************************************************************
    // timing configuration carrier
    // ****************************************************************
    typedef struct packed {
        logic               timing_multiplier_select;
        logic [FIELD_W-1:0] chip_select_assert_delay;
        logic [FIELD_W-1:0] chip_select_read_release;
        logic [FIELD_W-1:0] chip_select_write_release;
        logic [FIELD_W-1:0] latch_strobe_assert_delay;
        logic [FIELD_W-1:0] latch_strobe_read_release;
        logic [FIELD_W-1:0] latch_strobe_write_release;
        logic [FIELD_W-1:0] read_strobe_assert_delay;
        logic [FIELD_W-1:0] read_strobe_release;
        logic [FIELD_W-1:0] write_strobe_assert_delay;
        logic [FIELD_W-1:0] write_strobe_release;
        logic [FIELD_W-1:0] read_cycle_length;
        logic [FIELD_W-1:0] write_cycle_length;
        logic [FIELD_W-1:0] data_sample_delay;
        logic [PAGE_W-1:0]  page_word_interval;
        logic [PAGE_W-1:0]  inter_access_gap;
        logic               chip_select_half_cycle_shift;
        logic               latch_strobe_half_cycle_shift;
        logic               read_strobe_half_cycle_shift;
        logic               write_strobe_half_cycle_shift;
        logic [DIV_W-1:0]   bus_clock_divider;
    } anat_cfg_type;

    // ****************************************************************
    // access request carrier
    // ****************************************************************
    typedef struct packed {
        logic               write;      // single-word write
        logic               wide;       // 32-bit read as two halves
        logic [BURST_W-1:0] burst_m1;   // page words minus one
        logic [1:0]         cs_sel;     // chip select index
        logic [ADDR_W-1:0]  addr;       // word address
        logic [DATA_W-1:0]  wdata;      // write data
        logic [1:0]         byte_en_n;  // {high, low}, active low
    } anat_req_type;

    typedef enum logic [1:0] {
        ANAT_IDLE,
        ANAT_ACCESS,
        ANAT_GAP
    } anat_state_type;

    // ****************************************************************
    // whole module state
    // ****************************************************************
    typedef struct packed {
        anat_state_type     state;
        anat_req_type       req;        // latched request
        anat_cfg_type       cfg;        // latched timing
        logic [T_W-1:0]     cnt;        // half functional periods
        logic [T_W-1:0]     next_sample;
        logic [BURST_W-1:0] word_idx;   // page word in flight
        logic               half;       // second half of wide read
        logic [DATA_W-1:0]  din_meta;
        logic [DATA_W-1:0]  din_sync;
        logic [NUM_WT-1:0]  wait_meta;
        logic [NUM_WT-1:0]  wait_sync;
        logic [DIV_W-1:0]   div_cnt;
        logic               bus_clk;
        logic [NUM_CS-1:0]  cs_n;
        logic               lat_n;
        logic               rd_n;
        logic               wr_n;
        logic [1:0]         be_n;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  dout;
        logic               doe;
        logic [DATA_W-1:0]  rdata;
        logic               rvalid;
        logic               rhigh;
        logic               ready;
    } anat_st_type;

    localparam anat_st_type ST_RESET = '{
        state: ANAT_IDLE, req: '0, cfg: '0, cnt: '0, next_sample: '0,
        word_idx: '0, half: 1'b0, din_meta: '0, din_sync: '0,
        wait_meta: '0, wait_sync: '0, div_cnt: '0, bus_clk: 1'b0,
        cs_n: '1, lat_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, be_n: '1,
        addr: '0, dout: '0, doe: 1'b0, rdata: '0, rvalid: 1'b0,
        rhigh: 1'b0, ready: 1'b1};

endpackage

// ### logic/anat_edge_point.sv
// one strobe edge position on the access timeline
`timescale 1ns/1ps
module anat_edge_point
    import anat_pkg::*;
(
    input  wire logic [FIELD_W-1:0] base_in,   // programmed field
    input  wire logic [EXT_W-1:0]   ext_in,    // burst extension
    input  wire logic               mult_in,   // multiplier select
    input  wire logic               shift_in,  // half period shift
    output logic      [T_W-1:0]     point_out  // half periods from start
);
    // ********************
    // scaling
    // ********************
    logic [T_W-1:0] sum_w;  // field plus extension

    // one clk_in is half a functional period, hence the extra doubling
    always_comb begin
        sum_w = T_W'(base_in) + T_W'(ext_in);
        if (mult_in) begin
            point_out = T_W'(sum_w << 2) + T_W'(shift_in);
        end else begin
            point_out = T_W'(sum_w << 1) + T_W'(shift_in);
        end
    end
endmodule

// ### logic/anat_timing.sv
// timing generator for asynchronous nor flash accesses
`timescale 1ns/1ps
module anat_timing
(
    input  wire logic                          clk_in,      // 50 MHz
    input  wire logic                          rst_in,      // async, high
    input  wire anat_pkg::anat_cfg_type        cfg_in,      // timing fields
    input  wire logic                          req_valid_in,
    input  wire anat_pkg::anat_req_type        req_in,
    output logic                               req_ready_out,
    output logic [anat_pkg::DATA_W-1:0]        rd_data_out,
    output logic                               rd_valid_out,
    output logic                               rd_high_out, // wide upper half
    output logic [anat_pkg::NUM_CS-1:0]        chip_select_n_out,
    output logic                               address_latch_strobe_n_out,
    output logic                               read_strobe_n_out,
    output logic                               write_strobe_n_out,
    output logic                               low_byte_enable_n_out,
    output logic                               high_byte_enable_n_out,
    output logic [anat_pkg::ADDR_W-1:0]        address_out,
    input  wire logic [anat_pkg::DATA_W-1:0]   data_bus_in,
    output logic [anat_pkg::DATA_W-1:0]        data_bus_out,
    output logic                               data_bus_oe_out,
    input  wire logic [anat_pkg::NUM_WT-1:0]   wait_in,
    output logic [anat_pkg::NUM_WT-1:0]        wait_level_out,
    output logic                               external_bus_clock_out
);
    import anat_pkg::*;

    // ********************
    // state and timeline
    // ********************
    anat_st_type          st_ff;                 // registered state
    anat_st_type          nxt_st;                // next state
    logic [EXT_W-1:0]     burst_ext;             // (n-1) page intervals
    logic [FIELD_W-1:0]   base_a [NUM_EDGE];     // field per point
    logic [EXT_W-1:0]     ext_a  [NUM_EDGE];     // extension per point
    logic                 shift_a [NUM_EDGE];    // half shift per point
    logic [T_W-1:0]       pt     [NUM_EDGE];     // resulting points
    logic                 wr_acc;                // latched direction

    assign wr_acc = st_ff.req.write;

    // ********************
    // per-point inputs, picked by direction
    // ********************
    // points are absolute, so differences to select on fall out
    always_comb begin
        burst_ext = EXT_W'(st_ff.req.burst_m1) * EXT_W'(st_ff.cfg.page_word_interval);
        for (int i = 0; i < NUM_EDGE; i++) begin
            base_a[i]  = '0;
            ext_a[i]   = '0;
            shift_a[i] = 1'b0;
        end
        base_a[E_CS_ON]    = st_ff.cfg.chip_select_assert_delay;
        shift_a[E_CS_ON]   = st_ff.cfg.chip_select_half_cycle_shift;
        base_a[E_CS_OFF]   = wr_acc ? st_ff.cfg.chip_select_write_release
                                    : st_ff.cfg.chip_select_read_release;
        ext_a[E_CS_OFF]    = burst_ext;
        shift_a[E_CS_OFF]  = st_ff.cfg.chip_select_half_cycle_shift;
        base_a[E_LAT_ON]   = st_ff.cfg.latch_strobe_assert_delay;
        shift_a[E_LAT_ON]  = st_ff.cfg.latch_strobe_half_cycle_shift;
        base_a[E_LAT_OFF]  = wr_acc ? st_ff.cfg.latch_strobe_write_release
                                    : st_ff.cfg.latch_strobe_read_release;
        shift_a[E_LAT_OFF] = st_ff.cfg.latch_strobe_half_cycle_shift;
        base_a[E_RD_ON]    = st_ff.cfg.read_strobe_assert_delay;
        shift_a[E_RD_ON]   = st_ff.cfg.read_strobe_half_cycle_shift;
        base_a[E_RD_OFF]   = st_ff.cfg.read_strobe_release;
        ext_a[E_RD_OFF]    = burst_ext;
        shift_a[E_RD_OFF]  = st_ff.cfg.read_strobe_half_cycle_shift;
        base_a[E_WR_ON]    = st_ff.cfg.write_strobe_assert_delay;
        shift_a[E_WR_ON]   = st_ff.cfg.write_strobe_half_cycle_shift;
        base_a[E_WR_OFF]   = st_ff.cfg.write_strobe_release;
        shift_a[E_WR_OFF]  = st_ff.cfg.write_strobe_half_cycle_shift;
        base_a[E_CYC_END]  = wr_acc ? st_ff.cfg.write_cycle_length
                                    : st_ff.cfg.read_cycle_length;
        ext_a[E_CYC_END]   = burst_ext;
        base_a[E_SAMPLE]   = st_ff.cfg.data_sample_delay;
        base_a[E_PAGE]     = FIELD_W'(st_ff.cfg.page_word_interval);
        base_a[E_GAP]      = FIELD_W'(st_ff.cfg.inter_access_gap);
    end

    // ********************
    // point calculators
    // ********************
    genvar g;
    generate
        for (g = 0; g < NUM_EDGE; g++) begin : g_pt
            anat_edge_point u_pt (
                .base_in   (base_a[g]),
                .ext_in    (ext_a[g]),
                .mult_in   (st_ff.cfg.timing_multiplier_select),
                .shift_in  (shift_a[g]),
                .point_out (pt[g])
            );
        end
    endgenerate

    // ********************
    // next state
    // ********************
    // every pin lags the count by one cycle, so spacing stays exact
    always_comb begin
        logic in_acc;     // timeline running
        logic last_word;  // final page word in flight
        nxt_st        = st_ff;
        in_acc        = (st_ff.state == ANAT_ACCESS);
        last_word     = (st_ff.word_idx == st_ff.req.burst_m1);
        nxt_st.rvalid = 1'b0;

        // pin inputs pass two flops before use
        nxt_st.din_meta  = data_bus_in;
        nxt_st.din_sync  = st_ff.din_meta;
        nxt_st.wait_meta = wait_in;
        nxt_st.wait_sync = st_ff.wait_meta;

        // bus clock toggles every divider plus one cycles
        if (st_ff.div_cnt == st_ff.cfg.bus_clock_divider) begin
            nxt_st.div_cnt = DIV_ZERO;
            nxt_st.bus_clk = ~st_ff.bus_clk;
        end else begin
            nxt_st.div_cnt = st_ff.div_cnt + 2'h1;
        end

        unique case (st_ff.state)
            ANAT_IDLE: begin
                nxt_st.ready = 1'b1;
                if (req_valid_in && st_ff.ready) begin
                    // timing is frozen for the whole access
                    nxt_st.req      = req_in;
                    nxt_st.cfg      = cfg_in;
                    nxt_st.half     = 1'b0;
                    nxt_st.state    = ANAT_ACCESS;
                    nxt_st.cnt      = T_ZERO;
                    nxt_st.word_idx = '0;
                    nxt_st.ready    = 1'b0;
                    // wide reads and writes are single words
                    if (req_in.write || req_in.wide) begin
                        nxt_st.req.burst_m1 = BURST_ZERO;
                    end
                    nxt_st.next_sample = T_ZERO;
                end
            end
            ANAT_ACCESS: begin
                nxt_st.cnt = st_ff.cnt + T_ONE;
                if (st_ff.cnt == T_ZERO) begin
                    nxt_st.next_sample = pt[E_SAMPLE];
                end else if (!wr_acc && st_ff.cnt == st_ff.next_sample) begin
                    // take the word, step the page
                    nxt_st.rdata  = st_ff.din_sync;
                    nxt_st.rvalid = 1'b1;
                    nxt_st.rhigh  = st_ff.half;
                    if (!last_word) begin
                        nxt_st.word_idx    = st_ff.word_idx + 2'h1;
                        nxt_st.next_sample = st_ff.next_sample + pt[E_PAGE];
                    end else begin
                        nxt_st.next_sample = T_ZERO;  // no further sample
                    end
                end
                if (st_ff.cnt + T_ONE >= pt[E_CYC_END]) begin
                    nxt_st.state = ANAT_GAP;
                    nxt_st.cnt   = T_ZERO;
                end
            end
            ANAT_GAP: begin
                nxt_st.cnt = st_ff.cnt + T_ONE;
                if (st_ff.cnt >= pt[E_GAP]) begin
                    if (st_ff.req.wide && !st_ff.half) begin
                        // upper half goes out as a fresh single read
                        nxt_st.half     = 1'b1;
                        nxt_st.req.addr = st_ff.req.addr + ADDR_ONE;
                        nxt_st.state    = ANAT_ACCESS;
                        nxt_st.word_idx = '0;
                        nxt_st.cnt      = T_ZERO;
                    end else begin
                        nxt_st.state = ANAT_IDLE;
                        nxt_st.ready = 1'b1;
                    end
                end
            end
        endcase

        // pin levels from the current timeline position
        nxt_st.cs_n  = '1;
        nxt_st.lat_n = 1'b1;
        nxt_st.rd_n  = 1'b1;
        nxt_st.wr_n  = 1'b1;
        nxt_st.be_n  = '1;
        nxt_st.addr  = '0;   // address invalid outside the timeline
        nxt_st.doe   = 1'b0;
        if (in_acc) begin
            // address, enables and data lead chip select
            nxt_st.addr = st_ff.req.addr + ADDR_W'(st_ff.word_idx);
            nxt_st.be_n = st_ff.req.byte_en_n;
            if (wr_acc) begin
                nxt_st.dout = st_ff.req.wdata;
                nxt_st.doe  = 1'b1;
            end
            if (st_ff.cnt >= pt[E_CS_ON] && st_ff.cnt < pt[E_CS_OFF]) begin
                nxt_st.cs_n[st_ff.req.cs_sel] = 1'b0;
            end
            if (st_ff.cnt >= pt[E_LAT_ON] && st_ff.cnt < pt[E_LAT_OFF]) begin
                nxt_st.lat_n = 1'b0;
            end
            if (!wr_acc && st_ff.cnt >= pt[E_RD_ON] && st_ff.cnt < pt[E_RD_OFF]) begin
                nxt_st.rd_n = 1'b0;
            end
            if (wr_acc && st_ff.cnt >= pt[E_WR_ON] && st_ff.cnt < pt[E_WR_OFF]) begin
                nxt_st.wr_n = 1'b0;
            end
        end
    end

    // ********************
    // state register
    // ********************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ********************
    // outputs, all straight from flops
    // ********************
    // functional clock stays inside; only the divided bus clock leaves
    assign external_bus_clock_out     = st_ff.bus_clk;
    assign req_ready_out              = st_ff.ready;
    assign rd_data_out                = st_ff.rdata;
    assign rd_valid_out               = st_ff.rvalid;
    assign rd_high_out                = st_ff.rhigh;
    assign chip_select_n_out          = st_ff.cs_n;
    assign address_latch_strobe_n_out = st_ff.lat_n;
    assign read_strobe_n_out          = st_ff.rd_n;
    assign write_strobe_n_out         = st_ff.wr_n;
    assign low_byte_enable_n_out      = st_ff.be_n[0];
    assign high_byte_enable_n_out     = st_ff.be_n[1];
    assign address_out                = st_ff.addr;
    assign data_bus_out               = st_ff.dout;
    assign data_bus_oe_out            = st_ff.doe;
    assign wait_level_out             = st_ff.wait_sync;
endmodule

// ### bench/anat_props.sv
// timing checker for the nor access block
`timescale 1ns/1ps
module anat_props
    import anat_pkg::*;
(
    input wire logic                  clk_in,
    input wire logic                  rst_in,
    input wire anat_pkg::anat_cfg_type cfg_in,
    input wire logic                  req_valid_in,
    input wire anat_pkg::anat_req_type req_in,
    input wire logic                  req_ready_out,
    input wire logic                  rd_valid_out,
    input wire logic [3:0]            chip_select_n_out,
    input wire logic                  address_latch_strobe_n_out,
    input wire logic                  read_strobe_n_out,
    input wire logic                  write_strobe_n_out,
    input wire logic                  low_byte_enable_n_out,
    input wire logic                  high_byte_enable_n_out,
    input wire logic [26:0]           address_out,
    input wire logic                  external_bus_clock_out
);
    // ****
    // access shadow: config and request frozen at acceptance
    // ****
    logic         act_ff;  // single or burst access in flight
    logic [9:0]   t_ff;    // cycles since acceptance
    logic [9:0]   lv_ff;   // time of last read pulse
    logic [1:0]   nv_ff;   // read pulses so far
    anat_cfg_type c_ff;
    anat_req_type r_ff;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            {act_ff, t_ff, lv_ff, nv_ff, c_ff, r_ff} <= '0;
        end else if (req_valid_in && req_ready_out) begin
            {act_ff, t_ff, nv_ff} <= {!req_in.wide, 12'h000}; // wide halves not tracked
            {c_ff, r_ff} <= {cfg_in, req_in};
        end else begin
            t_ff <= t_ff + 10'h001;
            lv_ff <= rd_valid_out ? t_ff : lv_ff;
            nv_ff <= nv_ff + 2'(rd_valid_out);
            act_ff <= act_ff && !req_ready_out;
        end
    end
    // expected window edges in clock cycles; one functional period is two
    wire [9:0] m2 = c_ff.timing_multiplier_select ? 10'h004 : 10'h002;
    wire [9:0] k = t_ff - 10'h001;
    wire       w = r_ff.write;
    wire [9:0] ex = w ? 10'h000 : 10'(r_ff.burst_m1) * 10'(c_ff.page_word_interval);
    wire [9:0] cs = 10'(c_ff.chip_select_half_cycle_shift);
    wire [9:0] ls = 10'(c_ff.latch_strobe_half_cycle_shift);
    wire [9:0] rs = 10'(c_ff.read_strobe_half_cycle_shift);
    wire [9:0] ws = 10'(c_ff.write_strobe_half_cycle_shift);
    wire [9:0] crel = 10'(w ? c_ff.chip_select_write_release : c_ff.chip_select_read_release);
    wire [9:0] lrel = 10'(w ? c_ff.latch_strobe_write_release : c_ff.latch_strobe_read_release);
    wire [9:0] cyc = (10'(w ? c_ff.write_cycle_length : c_ff.read_cycle_length) + ex) * m2;
    wire       run = act_ff && t_ff != 10'h000 && !req_ready_out;
    function automatic logic inw(input logic [9:0] lo, input logic [9:0] hi);
        return k >= lo && k < hi;
    endfunction
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_cs; run |-> chip_select_n_out == (inw(10'(c_ff.chip_select_assert_delay) * m2 + cs,
        (crel + ex) * m2 + cs) ? ~(4'h1 << r_ff.cs_sel) : 4'hf); endproperty
    a_cs: assert property (p_cs) else $error("select window off");
    property p_lat; run |-> address_latch_strobe_n_out ==
        !inw(10'(c_ff.latch_strobe_assert_delay) * m2 + ls, lrel * m2 + ls); endproperty
    a_lat: assert property (p_lat) else $error("latch window off");
    property p_rd; run |-> read_strobe_n_out == (w || !inw(10'(c_ff.read_strobe_assert_delay)
        * m2 + rs, (10'(c_ff.read_strobe_release) + ex) * m2 + rs)); endproperty
    a_rd: assert property (p_rd) else $error("read strobe window off");
    property p_wr; run |-> write_strobe_n_out == (!w || !inw(10'(c_ff.write_strobe_assert_delay)
        * m2 + ws, 10'(c_ff.write_strobe_release) * m2 + ws)); endproperty
    a_wr: assert property (p_wr) else $error("write strobe window off");
    property p_adr; run && ex == 10'h000 |-> address_out == (k < cyc ? r_ff.addr : 27'h0); endproperty
    a_adr: assert property (p_adr) else $error("address wrong");
    property p_be; run && k < cyc |->
        {high_byte_enable_n_out, low_byte_enable_n_out} == r_ff.byte_en_n; endproperty
    a_be: assert property (p_be) else $error("byte enables wrong");
    property p_gap; $rose(req_ready_out) && act_ff |->
        k >= cyc + 10'(c_ff.inter_access_gap) * m2; endproperty
    a_gap: assert property (p_gap) else $error("gap too short");
    property p_s1; rd_valid_out && run && nv_ff == 2'h0 |->
        (t_ff - 10'(c_ff.data_sample_delay) * m2) inside {10'h001, 10'h002}; endproperty
    a_s1: assert property (p_s1) else $error("first sample misplaced");
    property p_pg; rd_valid_out && run && nv_ff != 2'h0 |->
        t_ff - lv_ff == 10'(c_ff.page_word_interval) * m2; endproperty
    a_pg: assert property (p_pg) else $error("page sample spacing wrong");
    property p_bc; (cfg_in.bus_clock_divider == 2'h0) [*3] |-> $changed(external_bus_clock_out);
    endproperty
    a_bc: assert property (p_bc) else $error("bus clock not at full rate");
    c_burst: cover property (rd_valid_out && nv_ff == 2'h3);
    c_wr: cover property (run && !write_strobe_n_out);
    c_x2: cover property (run && c_ff.timing_multiplier_select);
endmodule
bind anat_timing anat_props u_props (.*);

// ### bench/anat_flash_model.sv
// nor flash stand-in answering reads with an address-derived word
`timescale 1ns/1ps
module anat_flash_model (
    input  wire logic [3:0]  cs_n_in,  // any low = selected
    input  wire logic        clk_in,   // bench clock
    input  wire logic        rd_n_in,  // read strobe, active low
    input  wire logic [26:0] addr_in,  // word address
    output logic      [15:0] data_out  // level on the data pins
);
    logic [15:0] d_ff = 16'h0;
    wire         sel = cs_n_in != 4'hf && !rd_n_in;
    // answers at once; released pins flip every cycle so stale data cannot match
    always @(posedge clk_in) d_ff <= data_out;
    assign data_out = sel ? addr_in[15:0] ^ 16'h5a5a : ~d_ff;
endmodule

// ### bench/anat_timing_tb_top.sv
// self-checking bench for the nor access timing block
`timescale 1ns/1ps
module anat_timing_tb_top;
    import anat_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid = 1'b0;
    logic [1:0] wait_lvl = 2'h0;
    anat_cfg_type cfg = '0;
    anat_req_type req = '0;
    wire [15:0] rd_data, bus_in, bus_out, flash_d;
    wire [3:0] cs_n;
    wire [26:0] addr;
    wire [1:0] wait_q;
    wire rdy, rvld, rhi, lat_n, rd_n, wr_n, be0_n, be1_n, oe, bclk;
    int bad_count = 0;
    int compares = 0;
    initial forever #10 clk_in = ~clk_in;
    assign bus_in = oe ? bus_out : flash_d; // pin level from both drivers
    anat_timing uut (.clk_in(clk_in), .rst_in(rst_in), .cfg_in(cfg), .req_valid_in(req_valid),
        .req_in(req), .req_ready_out(rdy), .rd_data_out(rd_data), .rd_valid_out(rvld),
        .rd_high_out(rhi), .chip_select_n_out(cs_n), .address_latch_strobe_n_out(lat_n),
        .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n), .low_byte_enable_n_out(be0_n),
        .high_byte_enable_n_out(be1_n), .address_out(addr), .data_bus_in(bus_in),
        .data_bus_out(bus_out), .data_bus_oe_out(oe), .wait_in(wait_lvl),
        .wait_level_out(wait_q), .external_bus_clock_out(bclk));
    anat_flash_model u_flash (.cs_n_in(cs_n), .clk_in(clk_in), .rd_n_in(rd_n), .addr_in(addr),
        .data_out(flash_d));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****
    // one access: drive request, watch pins until idle again
    // ****
    task automatic access(input logic w, input logic wd, input logic [1:0] bm,
                          input logic [1:0] sel, input logic [26:0] a);
        int cyc, csn = 0, j = 0;
        int m2 = cfg.timing_multiplier_select ? 4 : 2;
        @(negedge clk_in);
        req = '{w, wd, bm, sel, a, ~a[15:0], sel};
        wait_lvl = sel;
        req_valid = 1'b1;
        @(negedge clk_in);
        req_valid = 1'b0;
        for (cyc = 0; cyc < 600 && rdy !== 1'b1; cyc++) begin
            if (cs_n !== 4'hf) csn++;
            if (w && cs_n !== 4'hf) check(32'({oe, bus_out}), 32'({1'b1, ~a[15:0]}));
            if (rvld === 1'b1) begin
                check(32'({rhi, rd_data}), 32'({wd & j[0], 16'(a + 27'(j)) ^ 16'h5a5a}));
                j++;
            end
            @(negedge clk_in);
        end
        if (cyc == 600) begin
            bad_count++;
            stop_test();
        end
        check(32'(csn), 32'(((w ? cfg.chip_select_write_release : cfg.chip_select_read_release
            + bm * cfg.page_word_interval) - cfg.chip_select_assert_delay) * m2 * (wd ? 2 : 1)));
        check(32'(j), 32'(w ? 0 : (wd ? 2 : bm + 1)));
        check(32'(wait_q), 32'(wait_lvl));
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        @(negedge clk_in) rst_in = 1'b0;
        for (int x = 0; x < 2; x++) begin
            cfg = '{x[0], 5'h1, 5'h6, 5'h5, 5'h1, 5'h3, 5'h2, 5'h2, 5'h7, 5'h1, 5'h4, 5'h8,
                    5'h6, 5'h5, 4'h2, 4'h2, x[0], 1'b0, 1'b1, 1'b1, 2'h0};
            // write then read on every select, bursts of one to four words
            for (int s = 0; s < 4; s++) begin
                access(1'b1, 1'b0, 2'h0, 2'(s), 27'(s * 4099 + 'h40001));
                access(1'b0, 1'b0, 2'(s), 2'(s), 27'(s * 77 + 'h7fff0));
            end
            access(1'b0, 1'b1, 2'h0, 2'h2, 27'h7ffffff);
        end
        stop_test();
    end
endmodule
